// ==== cgc_clock_gen_control.v ====
// Clock-generation control block with APB register access.
// Assumes a 125 MHz CLK, an APB master, and analog status inputs synchronous or resynchronised here.
`timescale 1ns/100ps
`include "cgc_regs.vh"
module cgc_clock_gen_control
#(
  parameter LOCK_CYCLES = `CGC_LOCK_CYCLES
)
(
  // Clock and reset.
  input wire CLK,
  input wire SYS_RST,
  // APB slave.
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [17:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  // Analog status inputs.
  input wire XTAL_STOPPED,
  input wire COMPARATOR_B_RAW,
  // Analog control outputs.
  output reg PLL_POWER_ENABLE,
  output reg BANDGAP_POWER_ENABLE,
  output reg OSC_MONITOR_ENABLE,
  output reg [1:0] COMPARATOR_B_POS_SEL,
  output reg COMPARATOR_B_NEG_SEL,
  // Clock multipliers, as factors of each base clock.
  output reg [2:0] ADC_CLOCK_MULTIPLIER,
  output reg [2:0] METERING_CLOCK_MULTIPLIER,
  output reg [5:0] CPU_CLOCK_MULTIPLIER,
  // Interrupt.
  output reg IRQ
);

// One-hot APB handshake states.
localparam ST_IDLE = 2'b01;
localparam ST_ACCESS = 2'b10;

// Positive-input codes: analog input two, analog input one.
localparam POS_IN2 = 2'b01;
localparam POS_IN1 = 2'b10;

reg [1:0] state;
reg [7:0] crystal_control_two;
reg [7:0] clock_select_control;
reg [7:0] pll_control;
reg [`CGC_IRQ_BITS-1:0] irq_status;
reg [`CGC_IRQ_BITS-1:0] irq_mask;
reg lock_q;
reg xtal_q;
reg cmpb_q;
reg [7:0] rd_byte;
reg addr_ok;
reg [`CGC_IRQ_BITS-1:0] next_irq_status;
reg [`CGC_IRQ_BITS-1:0] events;
reg [2:0] next_adc;
reg [2:0] next_met;
reg [5:0] next_cpu;
wire pll_locked_flag;
wire xtal_sync;
wire cmpb_sync;
wire [15:0] idx;
wire wr_now;
wire rd_now;
wire lock_visible;

assign idx = PADDR[17:2];
assign wr_now = (state == ST_ACCESS) && PSEL && PENABLE && PWRITE;
assign rd_now = (state == ST_IDLE) && PSEL && !PENABLE && !PWRITE;

// The lock bit is gated by the register bit as well as by the registered enable, so it
// reads zero from the very cycle in which software clears the PLL enable, before the
// analog side has followed.
assign lock_visible = pll_locked_flag && PLL_POWER_ENABLE && clock_select_control[`CGC_CLK_PLL_EN];

// Maps a two-bit select to a factor of 1, 2 or 4; code 11 falls back to 1.
function [2:0] mult3;
  input [1:0] code;
  begin
    case (code)
      2'b00: mult3 = 3'h1;
      2'b01: mult3 = 3'h2;
      2'b10: mult3 = 3'h4;
      default: mult3 = 3'h1;
    endcase
  end
endfunction

// The lock model sees the registered enables, the same levels that the analog side sees.
cgc_lock_timer #(
  .LOCK_CYCLES(LOCK_CYCLES),
  .CW(24)
) u_lock (
  .clk(CLK),
  .rst(SYS_RST),
  .pll_on(PLL_POWER_ENABLE),
  .bg_on(BANDGAP_POWER_ENABLE),
  .locked(pll_locked_flag)
);

// Both analog status levels are asynchronous to CLK and pass two flip-flops before any use.
cgc_sync u_xtal_sync (
  .clk(CLK),
  .rst(SYS_RST),
  .din(XTAL_STOPPED),
  .dout(xtal_sync)
);

cgc_sync u_cmpb_sync (
  .clk(CLK),
  .rst(SYS_RST),
  .din(COMPARATOR_B_RAW),
  .dout(cmpb_sync)
);

// Address decode and read mux.
always @*
begin
  addr_ok = 1'b1;
  rd_byte = 8'h00;
  case (idx)
    `CGC_IDX_PLL_LOCK_STATUS:
      rd_byte = {7'h00, lock_visible};
    `CGC_IDX_CRYSTAL_CTRL2:
      rd_byte = crystal_control_two;
    `CGC_IDX_CLOCK_SELECT:
      rd_byte = clock_select_control;
    `CGC_IDX_PLL_CONTROL:
      rd_byte = pll_control;
    // Bit 6 and bits 1:0 read zero, and bits 4:2 always read the fixed value five.
    `CGC_IDX_ANALOG_STATE:
      rd_byte = {xtal_sync, 1'b0, cmpb_sync, `CGC_ANA_FIXED, 2'b00};
    `CGC_IDX_IRQ_STATUS:
      rd_byte = {{(8-`CGC_IRQ_BITS){1'b0}}, irq_status};
    `CGC_IDX_IRQ_MASK:
      rd_byte = {{(8-`CGC_IRQ_BITS){1'b0}}, irq_mask};
    // A read-only copy of the CPU factor lets firmware confirm the doubler setting.
    `CGC_IDX_MULT_STATUS:
      rd_byte = {2'b00, CPU_CLOCK_MULTIPLIER};
    default:
      addr_ok = 1'b0;
  endcase
end

// APB handshake: setup, then one access cycle with PREADY high.
always @(posedge CLK or posedge SYS_RST)
begin
  if (SYS_RST)
  begin
    state <= ST_IDLE;
    PREADY <= 1'b0;
    PSLVERR <= 1'b0;
    PRDATA <= 32'h00000000;
  end
  else
  begin
    case (state)
      ST_IDLE:
      begin
        PREADY <= 1'b0;
        PSLVERR <= 1'b0;
        if (PSEL && !PENABLE)
        begin
          state <= ST_ACCESS;
          PREADY <= 1'b1;
          // An unmapped index is answered at once with an error, so firmware never stalls on it.
          PSLVERR <= !addr_ok;
          // Read data are captured at the setup edge and so stand unchanged through the access cycle.
          if (rd_now)
            PRDATA <= {24'h000000, rd_byte};
          else
            PRDATA <= 32'h00000000;
        end
      end
      ST_ACCESS:
      begin
        state <= ST_IDLE;
        PREADY <= 1'b0;
        PSLVERR <= 1'b0;
      end
      default:
      begin
        state <= ST_IDLE;
        PREADY <= 1'b0;
        PSLVERR <= 1'b0;
      end
    endcase
  end
end

// Software-written registers.
always @(posedge CLK or posedge SYS_RST)
begin
  if (SYS_RST)
  begin
    crystal_control_two <= `CGC_RST_VAL;
    clock_select_control <= `CGC_RST_VAL;
    pll_control <= `CGC_RST_VAL;
    irq_mask <= {`CGC_IRQ_BITS{1'b0}};
  end
  else if (wr_now)
  begin
    case (idx)
      // Bits software must keep at zero stay writable so misuse is visible on readback.
      `CGC_IDX_CRYSTAL_CTRL2:
        crystal_control_two <= PWDATA[7:0] & `CGC_CRY2_WMASK;
      `CGC_IDX_CLOCK_SELECT:
        clock_select_control <= PWDATA[7:0];
      `CGC_IDX_PLL_CONTROL:
        pll_control <= PWDATA[7:0] & `CGC_PLL_WMASK;
      `CGC_IDX_IRQ_MASK:
        irq_mask <= PWDATA[`CGC_IRQ_BITS-1:0];
      // Read-only registers and unmapped indices ignore writes.
      default:
        irq_mask <= irq_mask;
    endcase
  end
end

// Multiplier decode.
always @*
begin
  next_adc = mult3(clock_select_control[`CGC_CLK_ADC_HI:`CGC_CLK_ADC_LO]);
  next_met = mult3(clock_select_control[`CGC_CLK_MET_HI:`CGC_CLK_MET_LO]);
  next_cpu = 6'h01 << clock_select_control[`CGC_CLK_CPU_HI:`CGC_CLK_CPU_LO];
  // The second doubler has no effect unless the first one is set.
  if (pll_control[`CGC_PLL_DBL1])
  begin
    next_cpu = next_cpu << 1;
    if (pll_control[`CGC_PLL_DBL2])
      next_cpu = next_cpu << 1;
  end
end

// Control outputs, all from flip-flops.
always @(posedge CLK or posedge SYS_RST)
begin
  if (SYS_RST)
  begin
    PLL_POWER_ENABLE <= 1'b0;
    BANDGAP_POWER_ENABLE <= 1'b0;
    OSC_MONITOR_ENABLE <= 1'b0;
    // Reset routes input two against the reference, as select code 00 does.
    COMPARATOR_B_POS_SEL <= POS_IN2;
    COMPARATOR_B_NEG_SEL <= 1'b0;
    ADC_CLOCK_MULTIPLIER <= 3'h1;
    METERING_CLOCK_MULTIPLIER <= 3'h1;
    CPU_CLOCK_MULTIPLIER <= 6'h01;
  end
  else
  begin
    PLL_POWER_ENABLE <= clock_select_control[`CGC_CLK_PLL_EN];
    BANDGAP_POWER_ENABLE <= clock_select_control[`CGC_CLK_BG_EN];
    OSC_MONITOR_ENABLE <= crystal_control_two[`CGC_CRY2_OSC_MON];
    // Negative select: 0 picks the low-power reference, 1 picks analog input one.
    case (crystal_control_two[`CGC_CRY2_CMPB_HI:`CGC_CRY2_CMPB_LO])
      2'b00:
      begin
        COMPARATOR_B_POS_SEL <= POS_IN2;
        COMPARATOR_B_NEG_SEL <= 1'b0;
      end
      2'b01:
      begin
        COMPARATOR_B_POS_SEL <= POS_IN1;
        COMPARATOR_B_NEG_SEL <= 1'b0;
      end
      default:
      begin
        COMPARATOR_B_POS_SEL <= POS_IN2;
        COMPARATOR_B_NEG_SEL <= 1'b1;
      end
    endcase
    // Registered factors keep decode glitches away from the analog clock tree.
    ADC_CLOCK_MULTIPLIER <= next_adc;
    METERING_CLOCK_MULTIPLIER <= next_met;
    CPU_CLOCK_MULTIPLIER <= next_cpu;
  end
end

// Event detection and sticky interrupt status; a new event wins over a write-one clear.
always @*
begin
  events = {`CGC_IRQ_BITS{1'b0}};
  events[`CGC_IRQ_LOCK] = pll_locked_flag && !lock_q;
  events[`CGC_IRQ_UNLOCK] = !pll_locked_flag && lock_q;
  // Only the stop of the crystal is an event; its restart shows in the analog state register.
  events[`CGC_IRQ_XTAL_FAIL] = xtal_sync && !xtal_q;
  // Either crossing of the comparator counts.
  events[`CGC_IRQ_CMPB] = cmpb_sync != cmpb_q;
  // Flags a PLL enable while the bandgap is off, which software must avoid.
  // The enable is still passed on: flagging the misuse is cheaper than blocking it.
  events[`CGC_IRQ_SEQ_ERR] = clock_select_control[`CGC_CLK_PLL_EN] &&
                             !clock_select_control[`CGC_CLK_BG_EN] && !PLL_POWER_ENABLE;
  next_irq_status = irq_status;
  if (wr_now && idx == `CGC_IDX_IRQ_STATUS)
    next_irq_status = irq_status & ~PWDATA[`CGC_IRQ_BITS-1:0];
  next_irq_status = next_irq_status | events;
end

always @(posedge CLK or posedge SYS_RST)
begin
  if (SYS_RST)
  begin
    irq_status <= {`CGC_IRQ_BITS{1'b0}};
    lock_q <= 1'b0;
    xtal_q <= 1'b0;
    cmpb_q <= 1'b0;
    IRQ <= 1'b0;
  end
  else
  begin
    irq_status <= next_irq_status;
    lock_q <= pll_locked_flag;
    xtal_q <= xtal_sync;
    cmpb_q <= cmpb_sync;
    // Taken from the next status so that the line rises in the same cycle as the flag.
    IRQ <= |(next_irq_status & irq_mask);
  end
end

endmodule

// ==== cgc_regs.vh ====
// Register map, field positions, reset values and timing counts of the clock control block.
// Assumes a 32-bit APB slave at 125 MHz; offsets are word indices, byte address is four times the index.
`ifndef CGC_REGS_VH
`define CGC_REGS_VH

// Register indices, kept as printed; the byte address is the index times four.
`define CGC_IDX_PLL_LOCK_STATUS 16'h00a3
`define CGC_IDX_CRYSTAL_CTRL2 16'h2861
`define CGC_IDX_CLOCK_SELECT 16'h2867
`define CGC_IDX_PLL_CONTROL 16'h2868
`define CGC_IDX_ANALOG_STATE 16'h286b
`define CGC_IDX_IRQ_STATUS 16'h2870
`define CGC_IDX_IRQ_MASK 16'h2871
`define CGC_IDX_MULT_STATUS 16'h2872

// Crystal control two fields.
`define CGC_CRY2_RESERVED6 6
`define CGC_CRY2_OSC_MON 5
`define CGC_CRY2_CMPB_HI 3
`define CGC_CRY2_CMPB_LO 2
`define CGC_CRY2_WMASK 8'h6f

// Clock select control fields.
`define CGC_CLK_PLL_EN 7
`define CGC_CLK_BG_EN 6
`define CGC_CLK_ADC_HI 5
`define CGC_CLK_ADC_LO 4
`define CGC_CLK_MET_HI 3
`define CGC_CLK_MET_LO 2
`define CGC_CLK_CPU_HI 1
`define CGC_CLK_CPU_LO 0

// PLL control fields.
`define CGC_PLL_DBL2 7
`define CGC_PLL_DBL1 6
`define CGC_PLL_WMASK 8'he0

// Analog state register constant field.
`define CGC_ANA_FIXED 3'h5

// Interrupt status bits.
`define CGC_IRQ_LOCK 0
`define CGC_IRQ_UNLOCK 1
`define CGC_IRQ_XTAL_FAIL 2
`define CGC_IRQ_CMPB 3
`define CGC_IRQ_SEQ_ERR 4
`define CGC_IRQ_BITS 5

// Reset value of all control registers.
`define CGC_RST_VAL 8'h00

// PLL lock delay: time in microseconds and derived cycle count at 125 MHz.
`define CGC_LOCK_TIME_US 100
`define CGC_CLK_MHZ 125
`define CGC_LOCK_CYCLES (`CGC_LOCK_TIME_US * `CGC_CLK_MHZ)

`endif

// ==== cgc_sync.v ====
// Two-flop synchroniser for one asynchronous level.
// Assumes CLK of the receiving domain and an asynchronous active-high reset.
`timescale 1ns/100ps
module cgc_sync
(
  // Clock and reset.
  input wire clk,
  input wire rst,
  // Level in and out.
  input wire din,
  output reg dout
);

reg stage1;

always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    stage1 <= 1'b0;
    dout <= 1'b0;
  end
  else
  begin
    stage1 <= din;
    dout <= stage1;
  end
end

endmodule

// ==== cgc_lock_timer.v ====
// Models PLL lock as a fixed settling count after the PLL and bandgap are both on.
// Assumes one clock; the count restarts whenever either supply enable drops.
`timescale 1ns/100ps
module cgc_lock_timer
#(
  parameter LOCK_CYCLES = 12500,
  parameter CW = 24
)
(
  // Clock and reset.
  input wire clk,
  input wire rst,
  // Enables.
  input wire pll_on,
  input wire bg_on,
  // Lock out.
  output reg locked
);

reg [CW-1:0] count;

always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    count <= {CW{1'b0}};
    locked <= 1'b0;
  end
  else if (!(pll_on && bg_on))
  begin
    // Without the bandgap the PLL has no reference and cannot settle.
    count <= {CW{1'b0}};
    locked <= 1'b0;
  end
  else if (count == LOCK_CYCLES[CW-1:0] - 1'b1)
    locked <= 1'b1;
  else
    count <= count + 1'b1;
end

endmodule

// ==== cgc_clock_gen_control_properties.sv ====
// Concurrent checks on the APB answers and the control outputs of the clock control block.
// Assumes one clock domain and word indices on PADDR[17:2]; bound to the top module.
`timescale 1ns/100ps
module cgc_clock_gen_control_properties
#(
  parameter LOCK_CYCLES = 12500
)
(
  // Clock and reset.
  input wire CLK,
  input wire SYS_RST,
  // APB.
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [17:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [31:0] PRDATA,
  input wire PREADY,
  // Control outputs.
  input wire PLL_POWER_ENABLE,
  input wire BANDGAP_POWER_ENABLE,
  input wire OSC_MONITOR_ENABLE,
  input wire [1:0] COMPARATOR_B_POS_SEL,
  input wire COMPARATOR_B_NEG_SEL,
  input wire [2:0] ADC_CLOCK_MULTIPLIER,
  input wire [2:0] METERING_CLOCK_MULTIPLIER,
  input wire [5:0] CPU_CLOCK_MULTIPLIER
);
  wire acc = PSEL && PENABLE && PREADY;
  wire wr = acc && PWRITE;
  wire rd = acc && !PWRITE;
  wire [15:0] idx = PADDR[17:2];
  default clocking @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);

  // Outputs may lag the register by one cycle, so each is judged two edges after the write.
  property p_osc_wr;
    wr && idx == 16'h2861 |-> ##2 OSC_MONITOR_ENABLE == $past(PWDATA[5], 2);
  endproperty
  a_osc_wr: assert property (p_osc_wr) else $error("monitor enable wrong");
  property p_cmpb_route;
    wr && idx == 16'h2861 |-> ##2 COMPARATOR_B_NEG_SEL == $past(PWDATA[3], 2) &&
      COMPARATOR_B_POS_SEL == (($past(PWDATA[3:2], 2) == 2'h1) ? 2'h2 : 2'h1);
  endproperty
  a_cmpb_route: assert property (p_cmpb_route) else $error("comparator routing wrong");
  property p_lock_rd;
    rd && idx == 16'h00a3 |-> PRDATA[31:1] == 31'h0;
  endproperty
  a_lock_rd: assert property (p_lock_rd) else $error("lock status upper bits set");
  property p_pll_wr;
    wr && idx == 16'h2867 |-> ##2 PLL_POWER_ENABLE == $past(PWDATA[7], 2);
  endproperty
  a_pll_wr: assert property (p_pll_wr) else $error("pll enable wrong");
  property p_bg_wr;
    wr && idx == 16'h2867 |-> ##2 BANDGAP_POWER_ENABLE == $past(PWDATA[6], 2);
  endproperty
  a_bg_wr: assert property (p_bg_wr) else $error("bandgap enable wrong");
  property p_adc;
    ADC_CLOCK_MULTIPLIER inside {3'h1, 3'h2, 3'h4};
  endproperty
  a_adc: assert property (p_adc) else $error("adc factor illegal");
  property p_met;
    METERING_CLOCK_MULTIPLIER inside {3'h1, 3'h2, 3'h4};
  endproperty
  a_met: assert property (p_met) else $error("metering factor illegal");
  property p_cpu;
    $onehot(CPU_CLOCK_MULTIPLIER);
  endproperty
  a_cpu: assert property (p_cpu) else $error("cpu factor illegal");
  // Read data were built at the setup edge, so the enable is judged as it stood one edge earlier.
  property p_lock_off;
    rd && idx == 16'h00a3 && !$past(PLL_POWER_ENABLE) |-> !PRDATA[0];
  endproperty
  a_lock_off: assert property (p_lock_off) else $error("lock shown with pll off");
  property p_ana_rd;
    rd && idx == 16'h286b |-> PRDATA[31:8] == 24'h0 && PRDATA[6] == 1'b0 && PRDATA[4:0] == 5'h14;
  endproperty
  a_ana_rd: assert property (p_ana_rd) else $error("analog state fixed field wrong");
endmodule

bind cgc_clock_gen_control cgc_clock_gen_control_properties #(.LOCK_CYCLES(LOCK_CYCLES)) i_props (.CLK, .SYS_RST,
  .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PLL_POWER_ENABLE, .BANDGAP_POWER_ENABLE,
  .OSC_MONITOR_ENABLE, .COMPARATOR_B_POS_SEL, .COMPARATOR_B_NEG_SEL, .ADC_CLOCK_MULTIPLIER,
  .METERING_CLOCK_MULTIPLIER, .CPU_CLOCK_MULTIPLIER);

// ==== cgc_clock_gen_control_tb.sv ====
// Self-checking bench for the clock control block, driven over APB.
// Assumes a short lock count so the PLL settles within a few dozen cycles.
`timescale 1ns/100ps
module cgc_clock_gen_control_tb;
  logic CLK = 0, SYS_RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, XTAL_STOPPED = 0, COMPARATOR_B_RAW = 0;
  logic [17:0] PADDR = 18'h0;
  logic [31:0] PWDATA = 32'h0, PRDATA, r;
  logic PREADY, PSLVERR, PLL_POWER_ENABLE, BANDGAP_POWER_ENABLE, OSC_MONITOR_ENABLE, COMPARATOR_B_NEG_SEL, IRQ, err;
  logic [1:0] COMPARATOR_B_POS_SEL, c;
  logic [2:0] ADC_CLOCK_MULTIPLIER, METERING_CLOCK_MULTIPLIER, f;
  logic [5:0] CPU_CLOCK_MULTIPLIER;
  int fail_count = 0, num_checks = 0;

  cgc_clock_gen_control #(.LOCK_CYCLES(8)) i_dut (.CLK, .SYS_RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
    .PRDATA, .PREADY, .PSLVERR, .XTAL_STOPPED, .COMPARATOR_B_RAW, .PLL_POWER_ENABLE, .BANDGAP_POWER_ENABLE,
    .OSC_MONITOR_ENABLE, .COMPARATOR_B_POS_SEL, .COMPARATOR_B_NEG_SEL, .ADC_CLOCK_MULTIPLIER,
    .METERING_CLOCK_MULTIPLIER, .CPU_CLOCK_MULTIPLIER, .IRQ);

  always #4 CLK = ~CLK;

  task conclude;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask

  // Read data is taken at the very edge where PREADY is seen high, before that edge's updates land.
  task apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= {idx, 2'h0};
    PWDATA <= {24'h0, d};
    @(posedge CLK);
    PENABLE <= 1'b1;
    do
    begin
      @(posedge CLK);
      n++;
    end
    while (PREADY !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      fail_count++;
      conclude;
    end
    r = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task wr(input logic [15:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
    repeat (2) @(posedge CLK);
  endtask

  task rd(input logic [15:0] idx, input logic [31:0] e);
    apb(1'b0, idx, 8'h00);
    chk(r, e);
  endtask

  initial
  begin
    repeat (6) @(posedge CLK);
    SYS_RST <= 1'b0;
    chk({ADC_CLOCK_MULTIPLIER, METERING_CLOCK_MULTIPLIER}, {3'h1, 3'h1});
    chk(CPU_CLOCK_MULTIPLIER, 6'h1);
    chk({COMPARATOR_B_POS_SEL, COMPARATOR_B_NEG_SEL, IRQ}, {2'h1, 1'b0, 1'b0});
    chk({PLL_POWER_ENABLE, BANDGAP_POWER_ENABLE, OSC_MONITOR_ENABLE}, 3'h0);
    rd(16'h00a3, 32'h0);
    rd(16'h2861, 32'h0);
    rd(16'h2867, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      c = 2'(i);
      f = (c == 2'h3) ? 3'h1 : 3'h1 << c;
      wr(16'h2861, {4'h2, c, 2'h0});
      chk(OSC_MONITOR_ENABLE, 1'b1);
      chk({COMPARATOR_B_POS_SEL, COMPARATOR_B_NEG_SEL}, {(c == 2'h1) ? 2'h2 : 2'h1, c[1]});
      wr(16'h2867, {2'h0, c, c, c});
      chk({ADC_CLOCK_MULTIPLIER, METERING_CLOCK_MULTIPLIER}, {f, f});
      chk(CPU_CLOCK_MULTIPLIER, 6'h1 << c);
    end
    wr(16'h2861, 8'hff);
    rd(16'h2861, 32'h6f);
    wr(16'h2861, 8'h00);
    chk(OSC_MONITOR_ENABLE, 1'b0);
    wr(16'h2868, 8'h40);
    chk(CPU_CLOCK_MULTIPLIER, 6'h10);
    wr(16'h2868, 8'h80);
    chk(CPU_CLOCK_MULTIPLIER, 6'h08);
    wr(16'h2868, 8'hc0);
    chk(CPU_CLOCK_MULTIPLIER, 6'h20);
    rd(16'h2868, 32'hc0);
    rd(16'h2872, 32'h20);
    wr(16'h2867, 8'h40);
    chk({PLL_POWER_ENABLE, BANDGAP_POWER_ENABLE}, 2'h1);
    repeat (20) @(posedge CLK);
    rd(16'h00a3, 32'h0);
    wr(16'h2867, 8'hc0);
    chk({PLL_POWER_ENABLE, BANDGAP_POWER_ENABLE}, 2'h3);
    repeat (20) @(posedge CLK);
    rd(16'h00a3, 32'h1);
    apb(1'b0, 16'h2870, 8'h00);
    chk(r, 32'h1);
    chk(IRQ, 1'b0);
    wr(16'h2871, 8'h01);
    chk(IRQ, 1'b1);
    wr(16'h2870, 8'h01);
    chk(IRQ, 1'b0);
    wr(16'h2867, 8'h40);
    rd(16'h00a3, 32'h0);
    XTAL_STOPPED <= 1'b1;
    COMPARATOR_B_RAW <= 1'b1;
    repeat (5) @(posedge CLK);
    rd(16'h286b, 32'hb4);
    XTAL_STOPPED <= 1'b0;
    COMPARATOR_B_RAW <= 1'b0;
    repeat (5) @(posedge CLK);
    rd(16'h286b, 32'h14);
    apb(1'b0, 16'h2870, 8'h00);
    chk(r, 32'h0e);
    chk(IRQ, 1'b0);
    apb(1'b0, 16'h0001, 8'h00);
    chk({err, r[30:0]}, 32'h80000000);
    conclude;
  end
endmodule
